// *** rtl/iopx_pkg.sv ***
package iopx_pkg;

	// ****************************************************************
	// Register offsets on the plain register port.
	// ****************************************************************
	localparam logic [4:0] OFS_PORT_C_DIRECTION = 5'h00;
	localparam logic [4:0] OFS_PORT_C_PIN_LEVEL = 5'h01;
	localparam logic [4:0] OFS_PORT_D_OUTPUT = 5'h02;
	localparam logic [4:0] OFS_PORT_D_DIRECTION = 5'h03;
	localparam logic [4:0] OFS_PORT_D_PIN_LEVEL = 5'h04;
	localparam logic [4:0] OFS_PORT_E_OUTPUT = 5'h05;
	localparam logic [4:0] OFS_PORT_E_DIRECTION = 5'h06;
	localparam logic [4:0] OFS_PORT_E_PIN_LEVEL = 5'h07;
	localparam logic [4:0] OFS_PORT_F_OUTPUT = 5'h08;
	localparam logic [4:0] OFS_PORT_F_DIRECTION = 5'h09;
	localparam logic [4:0] OFS_PORT_F_PIN_LEVEL = 5'h0A;
	localparam logic [4:0] OFS_PORT_G_OUTPUT = 5'h0B;
	localparam logic [4:0] OFS_PORT_G_DIRECTION = 5'h0C;
	localparam logic [4:0] OFS_PORT_G_PIN_LEVEL = 5'h0D;
	localparam logic [4:0] OFS_LOWER_SENSE = 5'h0E;
	localparam logic [4:0] OFS_UPPER_SENSE = 5'h0F;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h10;
	localparam logic [4:0] OFS_IRQ_FLAGS = 5'h11;

	// ****************************************************************
	// Reset values and field layout.
	// ****************************************************************
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] RST_C_DIR_COMPAT = 8'hFF;
	localparam logic [7:0] PORT_G_MASK = 8'h1F;

	// ****************************************************************
	// Sense-control encodings.
	// ****************************************************************
	typedef enum logic [1:0] {
		IOPX_SENSE_LOW = 2'b00,
		IOPX_SENSE_ANY = 2'b01,
		IOPX_SENSE_FALL = 2'b10,
		IOPX_SENSE_RISE = 2'b11
	} iopx_sense_t;

	// ****************************************************************
	// Start-up timing at 125 MHz.
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 8000;
	localparam int STARTUP_TIME_NS = 4000;
	localparam int STARTUP_CYCLES = (STARTUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		IOPX_WAKE_IDLE = 2'b00,
		IOPX_WAKE_SAMPLE = 2'b01,
		IOPX_WAKE_START = 2'b10
	} iopx_wake_t;

endpackage : iopx_pkg

// *** rtl/iopx_ports.sv ***
`timescale 1ns/1ps
// Function
// - In compatibility mode port C resets to all outputs driving zero.
// - Port pins take reset state independent of any running clock.
// - In compatibility mode port F output and direction are unavailable; input only.
// - In compatibility mode port G registers are unavailable; alternate functions only.
// - Enabled external interrupts fire from pin activity even when pin is output.
// - Each external interrupt triggers on falling edge, rising edge or low level.
// - Enabled level interrupt requests continuously while the pin stays low.
// - Upper four edge detection uses the I/O clock; stops when it stops.
// - Low level and lower four edges are detected without a clock.
// - Asynchronously detected interrupts wake the device from every sleep mode; wake_request comes only from an enabled low level in power-down.
// - I/O clock stops in all sleep modes except idle.
// - Level wake-up from power-down needs two successive watchdog clock samples.
// - Wake when level seen in both samples, or held to start-up end.
// - Level vanishing before start-up end still wakes but raises no interrupt.
// - Lower sense decodes low level, reserved, async falling, async rising.
// - Upper sense decodes low level, any change, falling, rising between samples.
// - Flags set on trigger; clear on handler entry or software writing one.
// - Flags read as cleared while their input is level sensed.
module iopx_ports
	import iopx_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic compat_mode,
	input wire logic io_clk_run,
	input wire logic power_down,
	input wire logic wdt_tick,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] port_c_in,
	output logic [7:0] port_c_out,
	output logic [7:0] port_c_oe,
	input wire logic [7:0] port_d_in,
	output logic [7:0] port_d_out,
	output logic [7:0] port_d_oe,
	input wire logic [7:0] port_e_in,
	output logic [7:0] port_e_out,
	output logic [7:0] port_e_oe,
	input wire logic [7:0] port_f_in,
	output logic [7:0] port_f_out,
	output logic [7:0] port_f_oe,
	input wire logic [4:0] port_g_in,
	output logic [4:0] port_g_out,
	output logic [4:0] port_g_oe,
	output logic port_g_alt_only,
	input wire logic [7:0] ext_irq_pins,
	input wire logic [7:0] irq_ack,
	output logic [7:0] irq_request,
	output logic wake_request
);

	// ****************************************************************
	// Register state.
	// ****************************************************************
	logic [7:0] port_c_direction;
	logic [7:0] port_d_output;
	logic [7:0] port_d_direction;
	logic [7:0] port_e_output;
	logic [7:0] port_e_direction;
	logic [7:0] port_f_output;
	logic [7:0] port_f_direction;
	logic [7:0] port_g_output;
	logic [7:0] port_g_direction;
	logic [7:0] lower_sense_control;
	logic [7:0] upper_sense_control;
	logic [7:0] ext_irq_enable_mask;
	logic [7:0] ext_irq_flags;
	logic [7:0] pin_prev;
	logic [7:0] next_flags;
	logic [7:0] rdata_mux;
	logic [7:0] trig;
	logic [7:0] level_mode;
	logic [7:0] level_hit;
	iopx_wake_t wake_state;
	iopx_wake_t next_wake_state;
	logic [1:0] wake_samples;
	logic [15:0] start_cnt;
	logic level_any;

	// ****************************************************************
	// Address decode. Compatibility mode hides port F and G registers.
	// ****************************************************************
	wire wr_c_dir = reg_wr && reg_addr == OFS_PORT_C_DIRECTION;
	wire wr_d_out = reg_wr && reg_addr == OFS_PORT_D_OUTPUT;
	wire wr_d_dir = reg_wr && reg_addr == OFS_PORT_D_DIRECTION;
	wire wr_e_out = reg_wr && reg_addr == OFS_PORT_E_OUTPUT;
	wire wr_e_dir = reg_wr && reg_addr == OFS_PORT_E_DIRECTION;
	wire wr_f_out = reg_wr && !compat_mode && reg_addr == OFS_PORT_F_OUTPUT;
	wire wr_f_dir = reg_wr && !compat_mode && reg_addr == OFS_PORT_F_DIRECTION;
	wire wr_g_out = reg_wr && !compat_mode && reg_addr == OFS_PORT_G_OUTPUT;
	wire wr_g_dir = reg_wr && !compat_mode && reg_addr == OFS_PORT_G_DIRECTION;
	wire wr_lsc = reg_wr && reg_addr == OFS_LOWER_SENSE;
	wire wr_usc = reg_wr && reg_addr == OFS_UPPER_SENSE;
	wire wr_msk = reg_wr && reg_addr == OFS_IRQ_MASK;
	wire wr_flg = reg_wr && reg_addr == OFS_IRQ_FLAGS;

	// ****************************************************************
	// Port registers.
	// ****************************************************************
	// Port C reset depends on the mode: legacy parts came up with every pin an output.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			port_c_direction <= compat_mode ? RST_C_DIR_COMPAT : RST_REG;
		end else if (wr_c_dir) begin
			port_c_direction <= reg_wdata;
		end
	end

	// Data and direction registers for ports D to G.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			port_d_output <= RST_REG;
			port_d_direction <= RST_REG;
			port_e_output <= RST_REG;
			port_e_direction <= RST_REG;
			port_f_output <= RST_REG;
			port_f_direction <= RST_REG;
			port_g_output <= RST_REG;
			port_g_direction <= RST_REG;
		end else begin
			if (wr_d_out) port_d_output <= reg_wdata;
			if (wr_d_dir) port_d_direction <= reg_wdata;
			if (wr_e_out) port_e_output <= reg_wdata;
			if (wr_e_dir) port_e_direction <= reg_wdata;
			if (wr_f_out) port_f_output <= reg_wdata;
			if (wr_f_dir) port_f_direction <= reg_wdata;
			if (wr_g_out) port_g_output <= reg_wdata & PORT_G_MASK;
			if (wr_g_dir) port_g_direction <= reg_wdata & PORT_G_MASK;
		end
	end

	// Pin drive. Reset is forced combinationally so the pins need no clock edge.
	// Port C in compatibility mode is a push-pull zero output at reset.
	assign port_c_out = 8'h00;
	assign port_c_oe = sys_rst ? (compat_mode ? RST_C_DIR_COMPAT : RST_REG)
		: (compat_mode ? RST_C_DIR_COMPAT : port_c_direction);
	assign port_d_out = sys_rst ? RST_REG : port_d_output;
	assign port_d_oe = sys_rst ? RST_REG : port_d_direction;
	assign port_e_out = sys_rst ? RST_REG : port_e_output;
	assign port_e_oe = sys_rst ? RST_REG : port_e_direction;
	assign port_f_out = (sys_rst || compat_mode) ? RST_REG : port_f_output;
	assign port_f_oe = (sys_rst || compat_mode) ? RST_REG : port_f_direction;
	assign port_g_out = (sys_rst || compat_mode) ? 5'h00 : port_g_output[4:0];
	assign port_g_oe = (sys_rst || compat_mode) ? 5'h00 : port_g_direction[4:0];
	assign port_g_alt_only = compat_mode;

	// ****************************************************************
	// External interrupt sensing.
	// ****************************************************************
	// Sense registers reset to low level on every input.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lower_sense_control <= RST_REG;
			upper_sense_control <= RST_REG;
			ext_irq_enable_mask <= RST_REG;
		end else begin
			if (wr_lsc) lower_sense_control <= reg_wdata;
			if (wr_usc) upper_sense_control <= reg_wdata;
			if (wr_msk) ext_irq_enable_mask <= reg_wdata;
		end
	end

	// Previous pin sample. It follows the pins through reset as well, so the
	// first cycle after reset never shows a false edge on an idle-high pin.
	always_ff @(posedge mclk) begin
		pin_prev <= ext_irq_pins;
	end

	// Per-input trigger decode; the pins are sensed whatever the port direction.
	// The lower edges model an asynchronous latch sampled here; upper edges
	// need the I/O clock and are gated off while it is stopped.
	// The lower any-change code is reserved, so it never triggers.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sense
			logic [1:0] sc;
			logic rise;
			logic fall;
			logic clk_ok;
			if (gi < 4) begin : g_lo
				assign sc = lower_sense_control[2*gi +: 2];
				assign clk_ok = 1'b1;
			end else begin : g_hi
				assign sc = upper_sense_control[2*(gi-4) +: 2];
				assign clk_ok = io_clk_run;
			end
			assign rise = ext_irq_pins[gi] && !pin_prev[gi];
			assign fall = !ext_irq_pins[gi] && pin_prev[gi];
			assign level_mode[gi] = sc == IOPX_SENSE_LOW;
			assign level_hit[gi] = level_mode[gi] && !ext_irq_pins[gi];
			always_comb begin
				case (sc)
					IOPX_SENSE_ANY: trig[gi] = (gi >= 4) && clk_ok && (rise || fall);
					IOPX_SENSE_FALL: trig[gi] = clk_ok && fall;
					IOPX_SENSE_RISE: trig[gi] = clk_ok && rise;
					default: trig[gi] = 1'b0;
				endcase
			end
		end
	endgenerate

	// Flags: a trigger in the same cycle as a clear keeps the flag set.
	// Level-sensed inputs hold their flag cleared.
	assign next_flags = ((ext_irq_flags & ~(wr_flg ? reg_wdata : 8'h00) & ~irq_ack) | trig)
		& ~level_mode;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_irq_flags <= RST_REG;
		end else begin
			ext_irq_flags <= next_flags;
		end
	end

	assign irq_request = ext_irq_enable_mask & (ext_irq_flags | level_hit);

	// ****************************************************************
	// Level wake-up from power-down.
	// ****************************************************************
	assign level_any = |(ext_irq_enable_mask & level_hit);

	// Two watchdog samples accept the level; then start-up runs its course.
	// The level is checked in the idle and sample states but not in start-up, so a glitch shorter than two samples is ignored.
	always_comb begin
		next_wake_state = wake_state;
		case (wake_state)
			IOPX_WAKE_IDLE: if (power_down && level_any) next_wake_state = IOPX_WAKE_SAMPLE;
			IOPX_WAKE_SAMPLE: begin
				if (!level_any) next_wake_state = IOPX_WAKE_IDLE;
				else if (wdt_tick && wake_samples == 2'd1) next_wake_state = IOPX_WAKE_START;
			end
			IOPX_WAKE_START: if (start_cnt == 16'(STARTUP_CYCLES - 1))
				next_wake_state = IOPX_WAKE_IDLE;
			default: next_wake_state = IOPX_WAKE_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wake_state <= IOPX_WAKE_IDLE;
			wake_samples <= 2'd0;
			start_cnt <= 16'd0;
		end else begin
			wake_state <= next_wake_state;
			wake_samples <= (wake_state == IOPX_WAKE_SAMPLE && wdt_tick) ? wake_samples + 2'd1
				: (wake_state == IOPX_WAKE_SAMPLE ? wake_samples : 2'd0);
			start_cnt <= (wake_state == IOPX_WAKE_START) ? start_cnt + 16'd1 : 16'd0;
		end
	end

	// Wake fires at the end of start-up even if the level has gone; the
	// interrupt itself comes only from irq_request, so it is lost then.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= wake_state == IOPX_WAKE_START
				&& start_cnt == 16'(STARTUP_CYCLES - 1);
		end
	end

	// ****************************************************************
	// Read path; hidden registers and unmapped offsets read zero.
	// ****************************************************************
	always_comb begin
		case (reg_addr)
			OFS_PORT_C_DIRECTION: rdata_mux = port_c_direction;
			OFS_PORT_C_PIN_LEVEL: rdata_mux = port_c_in;
			OFS_PORT_D_OUTPUT: rdata_mux = port_d_output;
			OFS_PORT_D_DIRECTION: rdata_mux = port_d_direction;
			OFS_PORT_D_PIN_LEVEL: rdata_mux = port_d_in;
			OFS_PORT_E_OUTPUT: rdata_mux = port_e_output;
			OFS_PORT_E_DIRECTION: rdata_mux = port_e_direction;
			OFS_PORT_E_PIN_LEVEL: rdata_mux = port_e_in;
			OFS_PORT_F_OUTPUT: rdata_mux = compat_mode ? 8'h00 : port_f_output;
			OFS_PORT_F_DIRECTION: rdata_mux = compat_mode ? 8'h00 : port_f_direction;
			OFS_PORT_F_PIN_LEVEL: rdata_mux = port_f_in;
			OFS_PORT_G_OUTPUT: rdata_mux = compat_mode ? 8'h00 : port_g_output;
			OFS_PORT_G_DIRECTION: rdata_mux = compat_mode ? 8'h00 : port_g_direction;
			OFS_PORT_G_PIN_LEVEL: rdata_mux = compat_mode ? 8'h00 : {3'h0, port_g_in};
			OFS_LOWER_SENSE: rdata_mux = lower_sense_control;
			OFS_UPPER_SENSE: rdata_mux = upper_sense_control;
			OFS_IRQ_MASK: rdata_mux = ext_irq_enable_mask;
			OFS_IRQ_FLAGS: rdata_mux = ext_irq_flags;
			default: rdata_mux = 8'h00;
		endcase
	end

	// Read data is zero outside the cycle after a read, so stale data never looks valid.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_mux : 8'h00;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	chk_compat_c_out: assert property (@(posedge mclk) disable iff (sys_rst)
		compat_mode |-> port_c_oe == 8'hFF && port_c_out == 8'h00)
		else $error("port C not zero output in compat mode");
	chk_compat_f_hidden: assert property (@(posedge mclk) disable iff (sys_rst)
		compat_mode && reg_rd && reg_addr == OFS_PORT_F_OUTPUT |=> reg_rdata == 8'h00)
		else $error("port F output visible in compat mode");
	chk_compat_g_off: assert property (@(posedge mclk) disable iff (sys_rst)
		compat_mode |-> port_g_oe == 5'h00)
		else $error("port G driven in compat mode");
	chk_level_request: assert property (@(posedge mclk) disable iff (sys_rst)
		ext_irq_enable_mask[0] && lower_sense_control[1:0] == 2'b00 && !ext_irq_pins[0]
		|-> irq_request[0]) else $error("level request missing");
	chk_level_flag_zero: assert property (@(posedge mclk) disable iff (sys_rst)
		upper_sense_control[7:6] == 2'b00 |=> ext_irq_flags[7] == 1'b0)
		else $error("flag set in level mode");
	chk_flag_set_wins: assert property (@(posedge mclk) disable iff (sys_rst)
		trig[2] |=> ext_irq_flags[2]) else $error("trigger lost");
	chk_upper_clk_gate: assert property (@(posedge mclk) disable iff (sys_rst)
		!io_clk_run |-> trig[7:4] == 4'h0) else $error("upper edge without I/O clock");
	chk_pin_read: assert property (@(posedge mclk) disable iff (sys_rst)
		reg_rd && reg_addr == OFS_PORT_D_PIN_LEVEL |=> reg_rdata == $past(port_d_in))
		else $error("pin level read wrong");

	// ****************************************************************
	// Checks on reset drive, sensing, clearing, wake-up and compatibility reads.
	// ****************************************************************
	// Reset drive reaches the pins without waiting for software.
	chk_reset_pins: assert property (@(posedge mclk)
		sys_rst |-> port_d_oe == 8'h00 && port_e_oe == 8'h00 && port_f_oe == 8'h00
		&& port_g_oe == 5'h00) else $error("pins driven during reset");
	// The reserved lower code must never raise a flag.
	chk_lower_reserved: assert property (@(posedge mclk) disable iff (sys_rst)
		lower_sense_control[1:0] == 2'b01 |=> !$rose(ext_irq_flags[0]))
		else $error("reserved sense code raised a flag");
	// A lower falling edge is caught with the I/O clock stopped.
	chk_async_fall: assert property (@(posedge mclk) disable iff (sys_rst)
		!io_clk_run && lower_sense_control[3:2] == 2'b10 && pin_prev[1] && !ext_irq_pins[1]
		|=> ext_irq_flags[1]) else $error("lower falling edge lost");
	// Any change on an upper input counts while the I/O clock runs.
	chk_any_change: assert property (@(posedge mclk) disable iff (sys_rst)
		upper_sense_control[1:0] == 2'b01 && io_clk_run && ext_irq_pins[4] != pin_prev[4]
		|=> ext_irq_flags[4]) else $error("upper change lost");
	// An upper rising edge between samples sets its flag.
	chk_upper_rise: assert property (@(posedge mclk) disable iff (sys_rst)
		upper_sense_control[7:6] == 2'b11 && io_clk_run && ext_irq_pins[7] && !pin_prev[7]
		|=> ext_irq_flags[7]) else $error("upper rising edge lost");
	// Handler entry clears a flag when no new trigger arrives.
	chk_ack_clears: assert property (@(posedge mclk) disable iff (sys_rst)
		irq_ack[3] && !trig[3] |=> !ext_irq_flags[3])
		else $error("flag kept after handler entry");
	// Writing one clears a flag when no new trigger arrives.
	chk_write_clears: assert property (@(posedge mclk) disable iff (sys_rst)
		wr_flg && reg_wdata[5] && !trig[5] |=> !ext_irq_flags[5])
		else $error("flag kept after write of one");
	// Start-up may only begin on the second watchdog sample.
	chk_wake_two_ticks: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(wake_state == IOPX_WAKE_START)
		|-> $past(wdt_tick) && $past(wake_samples) == 2'd1) else $error("early start-up");
	// The wake request is a single-cycle pulse.
	chk_wake_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
		wake_request |=> !wake_request) else $error("wake request too long");
	// Hidden port G pin levels read as zero in compatibility mode.
	chk_compat_g_read: assert property (@(posedge mclk) disable iff (sys_rst)
		compat_mode && reg_rd && reg_addr == OFS_PORT_G_PIN_LEVEL |=> reg_rdata == 8'h00)
		else $error("port G pins visible in compat mode");

endmodule : iopx_ports

// *** test/io_ports_and_external_irq_tb.sv ***
`timescale 1ns/1ps
module io_ports_and_external_irq_tb;
	import iopx_pkg::*;
	logic mclk = 1'b0, sys_rst = 1'b1, compat_mode = 1'b0, io_clk_run = 1'b1;
	logic power_down = 1'b0, wdt_tick = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [4:0] reg_addr = 5'h00, port_g_in = 5'h00, port_g_out, port_g_oe;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, port_c_in = 8'h00, port_f_in = 8'h00;
	logic [7:0] irq_ack = 8'h00, bd = 8'hFF, be = 8'hFF, port_d_in, port_e_in, ext_irq_pins;
	logic [7:0] port_c_out, port_c_oe, port_d_out, port_d_oe, port_e_out, port_e_oe;
	logic [7:0] port_f_out, port_f_oe, irq_request, v[9];
	logic port_g_alt_only, wake_request;
	logic [15:0] lfsr = 16'h3D02;
	int err_total = 0, n_tests = 0;
	logic [4:0] rofs[9] = '{OFS_PORT_C_DIRECTION, OFS_PORT_D_OUTPUT, OFS_PORT_D_DIRECTION,
		OFS_PORT_E_OUTPUT, OFS_PORT_E_DIRECTION, OFS_PORT_F_OUTPUT, OFS_PORT_F_DIRECTION,
		OFS_PORT_G_OUTPUT, OFS_PORT_G_DIRECTION};

	// Free-running 125 MHz clock.
	always #4 mclk = ~mclk;

	iopx_ports DUT (.mclk, .sys_rst, .compat_mode, .io_clk_run, .power_down, .wdt_tick,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_c_in, .port_c_out,
		.port_c_oe, .port_d_in, .port_d_out, .port_d_oe, .port_e_in, .port_e_out,
		.port_e_oe, .port_f_in, .port_f_out, .port_f_oe, .port_g_in, .port_g_out,
		.port_g_oe, .port_g_alt_only, .ext_irq_pins, .irq_ack, .irq_request, .wake_request);
	iopx_board board (.board_d(bd), .board_e(be), .d_out(port_d_out), .d_oe(port_d_oe),
		.e_out(port_e_out), .e_oe(port_e_oe), .pin_d(port_d_in), .pin_e(port_e_in),
		.irq_pins(ext_irq_pins));

	// ****************************************************************
	// Helpers.
	// ****************************************************************
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd
	// Lower inputs have no any-change mode, and upper edges need the I/O clock.
	function automatic logic flag_exp(input int p, input logic [1:0] s, input logic fall,
		input logic cr);
		if (p >= 4 && !cr) return 1'b0;
		if (s == IOPX_SENSE_FALL) return fall;
		if (s == IOPX_SENSE_RISE) return !fall;
		return (s == IOPX_SENSE_ANY) && (p >= 4);
	endfunction : flag_exp
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rdchk
	task automatic setpin(input int p, input logic b);
		@(posedge mclk);
		if (p < 4) bd[p] <= b;
		else be[p] <= b;
	endtask : setpin
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done

	// Watchdog sized well beyond the few thousand cycles the sequence needs.
	initial begin
		#160000;
		err_total++;
		$display("[FAIL] %0t watchdog expired", $time);
		test_done();
	end

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		logic e;
		repeat (16) @(posedge mclk);
		chk(port_c_oe, 8'h00);
		sys_rst <= 1'b0;
		foreach (rofs[j]) rdchk(rofs[j], RST_REG);
		for (int a = 14; a < 18; a++) rdchk(5'(a), RST_REG);
		$display("reset values done");
		// Random register contents and pin levels; the port D pin register ignores writes.
		for (int i = 0; i < 12; i++) begin
			@(posedge mclk);
			foreach (v[j]) v[j] = rnd();
			bd <= rnd();
			be <= rnd();
			port_c_in <= rnd();
			port_f_in <= rnd();
			port_g_in <= 5'(rnd());
			foreach (v[j]) wr(rofs[j], v[j]);
			foreach (v[j]) rdchk(rofs[j], (j > 6) ? (v[j] & PORT_G_MASK) : v[j]);
			chk(port_c_oe, v[0]);
			chk(port_c_out, 8'h00);
			chk(port_d_out, v[1]);
			chk(port_d_oe, v[2]);
			chk(port_e_out, v[3]);
			chk(port_e_oe, v[4]);
			chk(port_f_out, v[5]);
			chk(port_f_oe, v[6]);
			chk({3'h0, port_g_out}, v[7] & PORT_G_MASK);
			chk({3'h0, port_g_oe}, v[8] & PORT_G_MASK);
			wr(OFS_PORT_D_PIN_LEVEL, ~port_d_in);
			rdchk(OFS_PORT_D_PIN_LEVEL, (v[1] & v[2]) | (bd & ~v[2]));
			rdchk(OFS_PORT_C_PIN_LEVEL, port_c_in);
			rdchk(OFS_PORT_F_PIN_LEVEL, port_f_in);
			rdchk(OFS_PORT_G_PIN_LEVEL, {3'h0, port_g_in});
		end
		wr(OFS_PORT_D_DIRECTION, 8'h00);
		wr(OFS_PORT_E_DIRECTION, 8'h00);
		bd <= 8'hFF;
		be <= 8'hFF;
		$display("register access done");
		// Every sense code on every input, with the I/O clock running and stopped.
		for (int cr = 1; cr >= 0; cr--) begin
			@(posedge mclk);
			io_clk_run <= cr[0];
			for (int p = 0; p < 8; p++) begin
				for (int s = 0; s < 4; s++) begin
					wr(p < 4 ? OFS_LOWER_SENSE : OFS_UPPER_SENSE, 8'(s << (2 * (p % 4))));
					wr(OFS_IRQ_FLAGS, 8'hFF);
					wr(OFS_IRQ_MASK, 8'(1 << p));
					setpin(p, 1'b0);
					e = flag_exp(p, 2'(s), 1'b1, cr[0]);
					rdchk(OFS_IRQ_FLAGS, 8'(e) << p);
					chk(irq_request, 8'(e | (s == 0)) << p);
					wr(OFS_IRQ_FLAGS, 8'(1 << p));
					rdchk(OFS_IRQ_FLAGS, 8'h00);
					setpin(p, 1'b1);
					e = flag_exp(p, 2'(s), 1'b0, cr[0]);
					rdchk(OFS_IRQ_FLAGS, 8'(e) << p);
					@(posedge mclk);
					irq_ack <= 8'(1 << p);
					@(posedge mclk);
					irq_ack <= 8'h00;
					rdchk(OFS_IRQ_FLAGS, 8'h00);
				end
			end
		end
		@(posedge mclk);
		io_clk_run <= 1'b1;
		$display("edge and level sensing done");
		// Software interrupt by writing a port pin that is an output.
		wr(OFS_PORT_D_DIRECTION, 8'h02);
		wr(OFS_PORT_D_OUTPUT, 8'h02);
		wr(OFS_LOWER_SENSE, 8'h08);
		wr(OFS_IRQ_FLAGS, 8'hFF);
		wr(OFS_IRQ_MASK, 8'h02);
		wr(OFS_PORT_D_OUTPUT, 8'h00);
		rdchk(OFS_IRQ_FLAGS, 8'h02);
		wr(OFS_PORT_D_DIRECTION, 8'h00);
		$display("software interrupt done");
		// Level wake from power-down, once with the level held and once with it dropped.
		wr(OFS_LOWER_SENSE, 8'h00);
		wr(OFS_IRQ_MASK, 8'h01);
		for (int h = 1; h >= 0; h--) begin
			int cnt;
			cnt = 0;
			@(posedge mclk);
			power_down <= 1'b1;
			io_clk_run <= 1'b0;
			bd[0] <= 1'b0;
			repeat (2) begin
				repeat (3) @(posedge mclk);
				wdt_tick <= 1'b1;
				@(posedge mclk);
				wdt_tick <= 1'b0;
			end
			if (h == 0) bd[0] <= 1'b1;
			while (wake_request !== 1'b1 && cnt < STARTUP_CYCLES + 8) begin
				@(posedge mclk);
				#1 cnt++;
			end
			chk(8'(cnt > STARTUP_CYCLES - 3 && cnt < STARTUP_CYCLES + 3), 8'h01);
			chk(irq_request, 8'(h));
			@(posedge mclk);
			power_down <= 1'b0;
			io_clk_run <= 1'b1;
			bd[0] <= 1'b1;
		end
		$display("wake-up done");
		// Legacy mode; port C registers are left alone by software apart from one read.
		@(posedge mclk);
		compat_mode <= 1'b1;
		sys_rst <= 1'b1;
		#1 chk(port_c_oe, RST_C_DIR_COMPAT);
		chk(port_c_out, 8'h00);
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		rdchk(OFS_PORT_C_DIRECTION, RST_C_DIR_COMPAT);
		for (int j = 5; j < 9; j++) wr(rofs[j], 8'hFF);
		for (int j = 5; j < 9; j++) rdchk(rofs[j], 8'h00);
		rdchk(OFS_PORT_G_PIN_LEVEL, 8'h00);
		rdchk(OFS_PORT_F_PIN_LEVEL, port_f_in);
		chk(port_f_oe, 8'h00);
		chk({2'h0, port_g_alt_only, port_g_oe}, 8'h20);
		$display("legacy mode done");
		test_done();
	end
endmodule : io_ports_and_external_irq_tb

// *** test/iopx_board.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Board side of ports D and E.
// ****************************************************************
module iopx_board (
	input wire logic [7:0] board_d,
	input wire logic [7:0] board_e,
	input wire logic [7:0] d_out,
	input wire logic [7:0] d_oe,
	input wire logic [7:0] e_out,
	input wire logic [7:0] e_oe,
	output logic [7:0] pin_d,
	output logic [7:0] pin_e,
	output logic [7:0] irq_pins
);
	// A driven bit shows the port's own level, so a port write can raise its interrupt.
	assign pin_d = (d_out & d_oe) | (board_d & ~d_oe);
	assign pin_e = (e_out & e_oe) | (board_e & ~e_oe);
	// Interrupt inputs share the low half of port D and the high half of port E.
	assign irq_pins = {pin_e[7:4], pin_d[3:0]};
endmodule : iopx_board
